// ===== scdac_pkg.sv
package scdac_pkg;
   // Byte addresses: printed offsets 0xfd/0xfe are not multiples of four
   localparam logic [7:0] IDX_DAC_COUNT = 8'hfd;
   localparam logic [7:0] IDX_SYS_CTRL = 8'hfe;
   localparam logic [11:0] ADDR_DAC_COUNT = {2'h0, IDX_DAC_COUNT, 2'h0};
   localparam logic [11:0] ADDR_SYS_CTRL = {2'h0, IDX_SYS_CTRL, 2'h0};
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h400;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h404;
   localparam logic [11:0] ADDR_SCRUB_CTRL = 12'h408;
   // Field positions of the system control register
   localparam int BOOT_FLAG_BIT = 7;
   localparam int OSC_RANGE_HI = 4;
   localparam int OSC_RANGE_LO = 3;
   localparam int KEEP_BIT = 0;
   localparam logic [7:0] SYS_CTRL_WMASK = 8'h19;
   // Reset values
   localparam logic [7:0] DAC_COUNT_RST = 8'h00;
   localparam logic [7:0] SYS_CTRL_RST = 8'h00;
   // Kept window of page 0 across a watchdog reset
   localparam logic [7:0] KEEP_LO = 8'h03;
   localparam logic [7:0] KEEP_HI = 8'hd7;
   // Oscillator range codes
   typedef enum logic [1:0]
   {
      SCDAC_OSC_12 = 2'b00,
      SCDAC_OSC_6 = 2'b01,
      SCDAC_OSC_24 = 2'b10,
      SCDAC_OSC_RSVD = 2'b11
   } scdac_osc_t;
   // Interrupt status bit positions
   localparam int IRQ_SCRUB_DONE = 0;
   localparam int IRQ_OSC_RSVD = 1;
   localparam int IRQ_BITS = 2;
endpackage : scdac_pkg

// ===== scdac_regs.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Count register holds 8-bit unsigned current units, 00 smallest, ff largest.
// - Current drives the analog bus only in DAC mode; also proximity charge.
// - Step size is scaled by the separate current-range field.
// - Bit 7 reads 1 when boot ran more than once, else 0; read only.
// - Bits 4:3 pick oscillator range 12, 6, 24; code 11 reserved.
// - With bit 0 clear, all SRAM is zeroed after any reset event.
// - With bit 0 set, page 0 addresses 03h to d7h survive a watchdog reset.
module scdac_regs #(
   parameter int RAM_AW = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic repeated_boot_i,
   input wire logic reset_event_i,
   input wire logic watchdog_reset_event_i,
   input wire logic dac_mode_en_i,
   input wire logic prox_mode_en_i,
   input wire logic [1:0] current_range_select_i,
   output logic [7:0] current_unit_count_o,
   output logic [1:0] current_range_o,
   output logic bus_drive_en_o,
   output logic prox_charge_en_o,
   output logic [1:0] osc_range_select_o,
   output logic sram_keep_on_watchdog_o,
   output logic sram_we_o,
   output logic [RAM_AW-1:0] sram_addr_o,
   output logic [7:0] sram_wdata_o,
   output logic sram_busy_o,
   output logic irq_o
);
   initial
   begin
      if (RAM_AW < 8 || RAM_AW > 16) $error("scdac_regs: RAM_AW must be 8..16");
   end

   logic [7:0] dac_r;
   logic [7:0] ctrl_r;
   logic boot_r;
   logic [scdac_pkg::IRQ_BITS-1:0] sts_r;
   logic [scdac_pkg::IRQ_BITS-1:0] sts_nxt;
   logic [scdac_pkg::IRQ_BITS-1:0] mask_r;
   logic [31:0] rdata_r;
   logic scrub_done;
   logic scrub_start_r;

   wire acc_w = psel_i && penable_i;
   wire wr_w = acc_w && pwrite_i && pstrb_i[0];
   wire sel_dac_w = (paddr_i == scdac_pkg::ADDR_DAC_COUNT);
   wire sel_ctrl_w = (paddr_i == scdac_pkg::ADDR_SYS_CTRL);
   wire sel_sts_w = (paddr_i == scdac_pkg::ADDR_IRQ_STATUS);
   wire sel_mask_w = (paddr_i == scdac_pkg::ADDR_IRQ_MASK);
   wire sel_scrub_w = (paddr_i == scdac_pkg::ADDR_SCRUB_CTRL);
   wire hit_w = sel_dac_w || sel_ctrl_w || sel_sts_w || sel_mask_w || sel_scrub_w;
   wire [1:0] osc_w = ctrl_r[scdac_pkg::OSC_RANGE_HI:scdac_pkg::OSC_RANGE_LO];
   wire osc_rsvd_w = (osc_w == scdac_pkg::SCDAC_OSC_RSVD);
   wire [7:0] ctrl_view_w = {boot_r, ctrl_r[6:0]};
   wire [31:0] rd_mux_w = sel_dac_w ? {24'h0, dac_r} :
                          sel_ctrl_w ? {24'h0, ctrl_view_w} :
                          sel_sts_w ? {30'h0, sts_r} :
                          sel_mask_w ? {30'h0, mask_r} :
                          sel_scrub_w ? {31'h0, sram_busy_o} : 32'h0;

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready_o = 1'b1;
   assign pslverr_o = acc_w && !hit_w;
   assign prdata_o = rdata_r;

   assign current_unit_count_o = dac_r;
   assign current_range_o = current_range_select_i;
   assign bus_drive_en_o = dac_mode_en_i;
   assign prox_charge_en_o = prox_mode_en_i;
   assign osc_range_select_o = osc_w;
   assign sram_keep_on_watchdog_o = ctrl_r[scdac_pkg::KEEP_BIT];
   assign sram_wdata_o = 8'h00;
   assign irq_o = |(sts_r & mask_r);

   // Status: set beats a write-one clear in the same cycle
   always_comb
   begin
      sts_nxt = sts_r;
      if (wr_w && sel_sts_w)
      begin
         sts_nxt = sts_r & ~pwdata_i[scdac_pkg::IRQ_BITS-1:0];
      end
      if (scrub_done)
      begin
         sts_nxt[scdac_pkg::IRQ_SCRUB_DONE] = 1'b1;
      end
      if (osc_rsvd_w)
      begin
         sts_nxt[scdac_pkg::IRQ_OSC_RSVD] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         dac_r <= scdac_pkg::DAC_COUNT_RST;
         ctrl_r <= scdac_pkg::SYS_CTRL_RST;
         sts_r <= '0;
         mask_r <= '0;
         rdata_r <= 32'h0;
      end
      else
      begin
         sts_r <= sts_nxt;
         // Load in the setup cycle so read data stands through the access phase
         if (psel_i && !penable_i && !pwrite_i)
         begin
            rdata_r <= rd_mux_w;
         end
         if (wr_w && sel_dac_w)
         begin
            dac_r <= pwdata_i[7:0];
         end
         if (wr_w && sel_ctrl_w)
         begin
            ctrl_r <= pwdata_i[7:0] & scdac_pkg::SYS_CTRL_WMASK;
         end
         if (wr_w && sel_mask_w)
         begin
            mask_r <= pwdata_i[scdac_pkg::IRQ_BITS-1:0];
         end
      end
   end

   // Boot flag is cleared while reset is high, then sampled from repeated_boot_i every cycle
   always_ff @(posedge sys_clk_i)
   begin
      boot_r <= rst_i ? 1'b0 : repeated_boot_i;
   end

   // Reset event starts a scrub; keep bit survives since ctrl is not reset by it
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         scrub_start_r <= 1'b0;
      end
      else
      begin
         scrub_start_r <= (reset_event_i || (wr_w && sel_scrub_w && pwdata_i[0]))
                          && !sram_busy_o;
      end
   end

   scdac_scrub #(
      .AW(RAM_AW)
   ) u_scrub (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .start_i(scrub_start_r),
      .keep_i(ctrl_r[scdac_pkg::KEEP_BIT]),
      .wdog_i(watchdog_reset_event_i),
      .busy_o(sram_busy_o),
      .done_o(scrub_done),
      .we_o(sram_we_o),
      .addr_o(sram_addr_o)
   );
endmodule : scdac_regs
`default_nettype wire

// ===== scdac_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module scdac_regs_chk #(
   parameter int RAM_AW = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic dac_mode_en_i,
   input wire logic [1:0] current_range_select_i,
   input wire logic [7:0] current_unit_count_o,
   input wire logic [1:0] current_range_o,
   input wire logic bus_drive_en_o,
   input wire logic [1:0] osc_range_select_o,
   input wire logic sram_keep_on_watchdog_o
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
   wire logic wr_d = wr && paddr_i == scdac_pkg::ADDR_DAC_COUNT;
   wire logic wr_c = wr && paddr_i == scdac_pkg::ADDR_SYS_CTRL;
   wire logic [2:0] ctl_q = {osc_range_select_o, sram_keep_on_watchdog_o};
   dac_load_a: assert property (wr_d |=> current_unit_count_o == $past(pwdata_i[7:0]))
      else $error("dac load");
   osc_load_a: assert property (wr_c |=> osc_range_select_o == $past(pwdata_i[4:3]))
      else $error("osc load");
   keep_load_a: assert property (wr_c |=> sram_keep_on_watchdog_o == $past(pwdata_i[0]))
      else $error("keep load");
   dac_hold_a: assert property (!wr_d |=> $stable(current_unit_count_o))
      else $error("dac hold");
   ctl_hold_a: assert property (!wr_c |=> $stable(ctl_q))
      else $error("ctrl hold");
   // Own disable: the check lands on the first cycle out of reset
   rst_zero_a: assert property (disable iff (1'b0) $fell(rst_i)
      |-> current_unit_count_o == 8'h00 && ctl_q == 3'h0) else $error("reset value");
   mux_drive_a: assert property (bus_drive_en_o == dac_mode_en_i)
      else $error("bus drive");
   range_pass_a: assert property (current_range_o == current_range_select_i)
      else $error("range pass");
endmodule : scdac_regs_chk
bind scdac_regs scdac_regs_chk #(.RAM_AW(RAM_AW)) chk_u (.*);
`default_nettype wire

// ===== scdac_scrub.sv
`timescale 1ns/10ps
`default_nettype none
// Walks SRAM addresses writing zero, skipping the kept window when asked
module scdac_scrub #(
   parameter int AW = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic keep_i,
   input wire logic wdog_i,
   output logic busy_o,
   output logic done_o,
   output logic we_o,
   output logic [AW-1:0] addr_o
);
   initial
   begin
      if (AW < 8) $error("scdac_scrub: AW must be at least 8");
   end

   typedef enum logic [0:0]
   {
      SCDAC_IDLE = 1'b0,
      SCDAC_RUN = 1'b1
   } scdac_scrub_t;

   scdac_scrub_t state_r;
   scdac_scrub_t state_nxt;
   logic [AW-1:0] addr_r;
   logic keep_r;
   logic done_r;
   wire last_w = &addr_r;
   // Shift rather than slice, so a page-0-only memory (AW of 8) stays legal
   wire in_page0_w = ((addr_r >> 8) == '0);
   wire in_win_w = in_page0_w && (addr_r[7:0] >= scdac_pkg::KEEP_LO)
                   && (addr_r[7:0] <= scdac_pkg::KEEP_HI);

   assign busy_o = (state_r == SCDAC_RUN);
   assign we_o = busy_o && !(keep_r && in_win_w);
   assign addr_o = addr_r;
   assign done_o = done_r;

   always_comb
   begin
      case (state_r)
         SCDAC_IDLE: state_nxt = start_i ? SCDAC_RUN : SCDAC_IDLE;
         SCDAC_RUN: state_nxt = last_w ? SCDAC_IDLE : SCDAC_RUN;
         default: state_nxt = SCDAC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state_r <= SCDAC_IDLE;
         addr_r <= '0;
         keep_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         done_r <= busy_o && last_w;
         if (state_r == SCDAC_IDLE && start_i)
         begin
            addr_r <= '0;
            keep_r <= keep_i && wdog_i;
         end
         else if (busy_o)
         begin
            addr_r <= addr_r + 1'b1;
         end
      end
   end
endmodule : scdac_scrub
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module tb_top;
   logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, er;
   logic repeated_boot_i, reset_event_i, watchdog_reset_event_i, dac_mode_en_i;
   logic prox_mode_en_i, bus_drive_en_o, prox_charge_en_o, sram_keep_on_watchdog_o;
   logic sram_we_o, sram_busy_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0] pstrb_i;
   logic [1:0] current_range_select_i, current_range_o, osc_range_select_o;
   logic [7:0] current_unit_count_o, sram_addr_o, sram_wdata_o;
   int miscompares, samples_checked, n_wr, n_kp;
   scdac_regs dut_u (.*);
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i)
      if (sram_we_o === 1'b1)
      begin
         n_wr++;
         n_kp += int'(sram_addr_o inside {[8'h03:8'hd7]});
      end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // Bounded wait, a hang counts as a mismatch
   task automatic wt(ref logic s, input logic lv);
      int n;
      for (n = 0; n < 400 && s !== lv; n++)
         @(posedge sys_clk_i);
      if (n == 400)
      begin
         miscompares++;
         give_verdict();
      end
   endtask : wt
   // Request held until pready is sampled high; answer taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk_i);
      {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      for (n = 0; n < 400; n++)
      begin
         @(posedge sys_clk_i);
         if (pready_o === 1'b1)
            break;
      end
      if (n == 400)
      begin
         miscompares++;
         give_verdict();
      end
      er = pslverr_o;
      rd = prdata_o;
      {psel_i, penable_i} <= 2'b00;
   endtask : apb
   task automatic t_dac;
      apb(1'b1, scdac_pkg::ADDR_DAC_COUNT, 32'hff);
      apb(1'b0, scdac_pkg::ADDR_DAC_COUNT, 32'h0);
      `CHK("dac max", 8'hff, rd);
      apb(1'b1, scdac_pkg::ADDR_DAC_COUNT, 32'h0);
      @(posedge sys_clk_i);
      `CHK("dac min", 8'h00, current_unit_count_o);
      apb(1'b0, 12'h100, 32'h0);
      `CHK("slverr", 1'b1, er);
      `CHK("unmapped read", 0, rd);
   endtask : t_dac
   // reserved bits always written as zero here
   // trim reload is software work outside this block
   task automatic t_ctl;
      logic [7:0] d;
      for (int c = 0; c < 3; c++)
      begin
         d = {3'h0, 2'(c), 2'h0, c[0]};
         apb(1'b1, scdac_pkg::ADDR_SYS_CTRL, {24'h0, d});
         apb(1'b0, scdac_pkg::ADDR_SYS_CTRL, 32'h0);
         `CHK("ctrl", d, rd);
         `CHK("osc out", c, osc_range_select_o);
         `CHK("keep out", c[0], sram_keep_on_watchdog_o);
      end
      @(posedge sys_clk_i);
      repeated_boot_i <= 1'b1;
      apb(1'b1, scdac_pkg::ADDR_SYS_CTRL, 32'h0);
      apb(1'b0, scdac_pkg::ADDR_SYS_CTRL, 32'h0);
      `CHK("boot flag", 8'h80, rd);
   endtask : t_ctl
   task automatic t_irq;
      apb(1'b1, scdac_pkg::ADDR_SYS_CTRL, 32'h18);
      apb(1'b1, scdac_pkg::ADDR_IRQ_MASK, 32'h2);
      apb(1'b0, scdac_pkg::ADDR_IRQ_STATUS, 32'h0);
      `CHK("irq status", 32'h2, rd);
      `CHK("irq on", 1'b1, irq_o);
      apb(1'b1, scdac_pkg::ADDR_IRQ_MASK, 32'h0);
      apb(1'b1, scdac_pkg::ADDR_SYS_CTRL, 32'h0);
      `CHK("irq masked", 1'b0, irq_o);
      apb(1'b1, scdac_pkg::ADDR_IRQ_STATUS, 32'h2);
      apb(1'b0, scdac_pkg::ADDR_IRQ_STATUS, 32'h0);
      `CHK("status clear", 0, rd);
   endtask : t_irq
   // scrub writes, window kept only on watchdog
   task automatic t_scrub(input logic kp, input logic wd, input int nw, input int nk);
      apb(1'b1, scdac_pkg::ADDR_SYS_CTRL, {31'h0, kp});
      @(posedge sys_clk_i);
      {n_wr, n_kp} = '0;
      {reset_event_i, watchdog_reset_event_i, dac_mode_en_i} <= {1'b1, wd, wd};
      current_range_select_i <= {kp, wd};
      prox_mode_en_i <= wd;
      @(posedge sys_clk_i);
      reset_event_i <= 1'b0;
      wt(sram_busy_o, 1'b1);
      wt(sram_busy_o, 1'b0);
      watchdog_reset_event_i <= 1'b0;
      apb(1'b0, scdac_pkg::ADDR_IRQ_STATUS, 32'h0);
      `CHK("done flag", 1'b1, rd[0]);
      `CHK("writes", nw, n_wr);
      `CHK("window writes", nk, n_kp);
      `CHK("bus drive", wd, bus_drive_en_o);
      `CHK("prox charge", wd, prox_charge_en_o);
      `CHK("range out", {kp, wd}, current_range_o);
      `CHK("scrub data", 8'h00, sram_wdata_o);
      apb(1'b1, scdac_pkg::ADDR_IRQ_STATUS, 32'h1);
   endtask : t_scrub
   initial
   begin
      {psel_i, penable_i, pwrite_i, reset_event_i, watchdog_reset_event_i} = '0;
      {repeated_boot_i, prox_mode_en_i, paddr_i, pwdata_i} = '0;
      {miscompares, samples_checked} = '0;
      pstrb_i = 4'hf;
      rst_i = 1'b1;
      dac_mode_en_i = 1'b1;
      current_range_select_i = 2'b10;
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_dac;
      t_ctl;
      t_irq;
      t_scrub(1'b0, 1'b1, 256, 213);
      t_scrub(1'b1, 1'b1, 43, 0);
      t_scrub(1'b1, 1'b0, 256, 213);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
